// >>> dma_cfg_pkg.sv
// Purpose: Shared constants, types and helpers for the DMA pin configuration block.
// Assumes: Registers are one byte wide and sit in the low lane of a 32-bit word.
// Notes: Strobe widths are counted in core clock cycles.
`default_nettype none
package dma_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int STROBE_CNT_W = 8;

  localparam logic [7:0] HW_REG_OFFSET = 8'h3c;
  localparam logic [7:0] STROBE_REG_OFFSET = 8'h60;
  localparam logic [7:0] STATUS_REG_OFFSET = 8'h64;

  localparam logic [7:0] HW_REG_RESET = 8'h04;
  localparam logic [7:0] STROBE_REG_RESET = 8'h1f;

  localparam int SWAP_MSB = 7;
  localparam int SWAP_LSB = 6;
  localparam int END_LEVEL_BIT = 5;
  localparam int MASTER_BIT = 4;
  localparam int ACK_LEVEL_BIT = 3;
  localparam int REQ_LEVEL_BIT = 2;
  localparam int WRITE_LEVEL_BIT = 1;
  localparam int READ_LEVEL_BIT = 0;
  localparam int STROBE_CNT_MSB = 4;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REQ_EN_BIT = 1;
  localparam int STAT_ACK_BIT = 2;
  localparam int STAT_END_BIT = 3;

  localparam logic [1:0] SWAP_NORMAL = 2'h0;
  localparam logic [1:0] SWAP_ON = 2'h1;
  localparam logic [1:0] TIMED_MODE = 2'h3;
  localparam logic [4:0] FIXED_STROBE_COUNT = 5'h03;

  localparam int STROBE_UNIT_PS = 33300;
  localparam int CORE_PERIOD_PS = 25000;
  localparam int STROBE_UNIT_CYCLES = (STROBE_UNIT_PS / CORE_PERIOD_PS) < 1 ? 1 : (STROBE_UNIT_PS / CORE_PERIOD_PS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {ST_IDLE = 1'b0, ST_ACTIVE = 1'b1} strobe_state_t;

  // A pin is active when it equals its selected level; the same form drives and decodes.
  function automatic logic levelOf(input logic act, input logic sel);
    return act ~^ sel;
  endfunction

  function automatic logic [15:0] swapBytes(input logic [15:0] w);
    return {w[7:0], w[15:8]};
  endfunction

  function automatic logic [STROBE_CNT_W-1:0] strobeCycles(input logic [4:0] n);
    return STROBE_CNT_W'(({3'h0, n} + 8'h01) * STROBE_UNIT_CYCLES);
  endfunction
endpackage
`default_nettype wire

// >>> dma_cfg_if.sv
// Purpose: Carries the decoded configuration from the top to its helpers.
// Assumes: Driven by the top only, from its registers and the genericDmaActive and transferMode inputs.
// Notes: No clocking; all fields are levels.
`timescale 1ns/1ps
`default_nettype none
interface dma_cfg_if;
  logic [1:0] byteLaneSwap;
  logic genericActive;
  logic timedStrobe;
  logic [4:0] strobeWidthCount;
  modport src(output byteLaneSwap, output genericActive, output timedStrobe, output strobeWidthCount);
  modport timer(input timedStrobe, input strobeWidthCount);
  modport lanes(input byteLaneSwap, input genericActive);
endinterface
`default_nettype wire

// >>> strobe_timer.sv
// Purpose: Generates one master read or write strobe of programmed width.
// Assumes: startStrobe is ignored while a strobe is active.
// Notes: At least one idle cycle separates two strobes.
`timescale 1ns/1ps
`default_nettype none
module strobe_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  dma_cfg_if.timer cfg,
  input wire logic startStrobe,
  input wire logic startRead,
  output logic strobeActive,
  output logic strobeRead,
  output logic busy
);
  import dma_cfg_pkg::*;
  strobe_state_t state, next_state;
  logic [STROBE_CNT_W-1:0] remain, next_remain;
  logic next_strobeRead;

  always_comb begin
    next_state = state;
    next_remain = remain;
    next_strobeRead = strobeRead;
    case (state)
      ST_IDLE: begin
        if (startStrobe) begin
          next_state = ST_ACTIVE;
          // Outside the timed mode the width falls back to a fixed count.
          next_remain = strobeCycles(cfg.timedStrobe ? cfg.strobeWidthCount : FIXED_STROBE_COUNT) - 8'h01;
          next_strobeRead = startRead;
        end
      end
      ST_ACTIVE: begin
        if (remain == 8'h00) begin
          next_state = ST_IDLE;
        end else begin
          next_remain = remain - 8'h01;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      remain <= 8'h00;
      strobeRead <= 1'b0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      strobeRead <= next_strobeRead;
    end
  end

  assign strobeActive = (state == ST_ACTIVE);
  assign busy = (state == ST_ACTIVE);
endmodule
`default_nettype wire

// >>> lane_swap.sv
// Purpose: Moves 16-bit words between internal RAM and the DMA bus, swapping lanes on request.
// Assumes: Words are presented every cycle; one cycle of latency each way.
// Notes: Reserved swap codes behave as normal order.
`timescale 1ns/1ps
`default_nettype none
module lane_swap (
  input wire logic core_clk,
  input wire logic rst_n,
  dma_cfg_if.lanes cfg,
  input wire logic [15:0] ramWord,
  input wire logic [15:0] busWordIn,
  output logic [15:0] busWordOut,
  output logic [15:0] ramWordOut
);
  import dma_cfg_pkg::*;
  logic swapOn;
  logic [15:0] next_busWordOut, next_ramWordOut;

  always_comb begin
    swapOn = cfg.genericActive && (cfg.byteLaneSwap == SWAP_ON);
    next_busWordOut = swapOn ? swapBytes(ramWord) : ramWord;
    next_ramWordOut = swapOn ? swapBytes(busWordIn) : busWordIn;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busWordOut <= 16'h0000;
      ramWordOut <= 16'h0000;
    end else begin
      busWordOut <= next_busWordOut;
      ramWordOut <= next_ramWordOut;
    end
  end
endmodule
`default_nettype wire

// >>> dma_pin_config.sv
// Purpose: Pin polarity, role, lane swap and strobe width control of the external DMA bus.
// Assumes: AXI4-Lite register access; DMA pins synchronous to core_clk.
// Notes: Handshake outputs follow the registers combinationally.
// Overview of operation
// - Swap code 01 puts the high byte on the low lane; 00 keeps order.
// - Lane swapping acts only in generic slave and master DMA modes.
// - Bit 5 picks the end-of-transfer input level; it matters in slave mode only.
// - Bit 4 picks slave role (0) or master role driving strobes (1).
// - Bit 3 picks acknowledge level: 0 low, 1 high.
// - Bit 2 picks request level: 0 low, 1 high; reset value is high.
// - Bit 1 picks write strobe level: 0 low, 1 high.
// - Bit 0 picks read strobe level: 0 low, 1 high.
// - Programmed strobe width applies only in master role with transfer mode 03.
// - Each timed strobe stays active for count plus one cycles.
// - One strobe step equals one internal clock period.
// - The request pin stays undriven until the DMA configuration is first written.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dma_pin_config (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [dma_cfg_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [dma_cfg_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic dmaConfigWrite,
  input wire logic [1:0] transferMode,
  input wire logic genericDmaActive,
  input wire logic coreRequest,
  input wire logic startStrobe,
  input wire logic startRead,
  input wire logic [15:0] ramWord,
  input wire logic [15:0] busWordIn,
  output logic [15:0] busWordOut,
  output logic [15:0] ramWordOut,
  output logic dmaRequestPin,
  output logic dmaRequestOe,
  input wire logic acknowledgePin,
  input wire logic transferEndInput,
  input wire logic readStrobeIn,
  output logic readStrobeOut,
  output logic readStrobeOe,
  input wire logic writeStrobeIn,
  output logic writeStrobeOut,
  output logic writeStrobeOe,
  output logic acknowledgeActive,
  output logic transferEndActive,
  output logic slaveReadStrobe,
  output logic slaveWriteStrobe,
  output logic strobeBusy
);
  import dma_cfg_pkg::*;

  logic [7:0] hwReg, next_hwReg;
  logic [7:0] strobeReg, next_strobeReg;
  logic reqEnabled, next_reqEnabled;
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [ADDR_W-1:0] awAddrHeld, next_awAddrHeld;
  logic [7:0] wByteHeld, next_wByteHeld;
  logic wLaneHeld, next_wLaneHeld;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic [7:0] statusByte;
  logic masterDma, strobeActive, strobeRead;
  dma_cfg_if cfg ();

  function automatic logic [ADDR_W-1:0] alignedOf(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;

  // Write path: address and data are caught independently and committed together.
  always_comb begin
    next_awHeld = awHeld;
    next_awAddrHeld = awAddrHeld;
    next_wHeld = wHeld;
    next_wByteHeld = wByteHeld;
    next_wLaneHeld = wLaneHeld;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_hwReg = hwReg;
    next_strobeReg = strobeReg;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awAddrHeld = alignedOf(awaddr);
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_wByteHeld = wdata[7:0];
      next_wLaneHeld = wstrb[0];
    end
    if (awHeld && wHeld) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (awAddrHeld == HW_REG_OFFSET) begin
        if (wLaneHeld) begin
          next_hwReg = wByteHeld;
        end
      end else if (awAddrHeld == STROBE_REG_OFFSET) begin
        if (wLaneHeld) begin
          next_strobeReg = wByteHeld;
        end
      end else if (awAddrHeld == STATUS_REG_OFFSET) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddrHeld <= '0;
      wHeld <= 1'b0;
      wByteHeld <= 8'h00;
      wLaneHeld <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      hwReg <= HW_REG_RESET;
      strobeReg <= STROBE_REG_RESET;
    end else begin
      awHeld <= next_awHeld;
      awAddrHeld <= next_awAddrHeld;
      wHeld <= next_wHeld;
      wByteHeld <= next_wByteHeld;
      wLaneHeld <= next_wLaneHeld;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      hwReg <= next_hwReg;
      strobeReg <= next_strobeReg;
    end
  end

  always_comb begin
    statusByte = 8'h00;
    statusByte[STAT_BUSY_BIT] = strobeBusy;
    statusByte[STAT_REQ_EN_BIT] = reqEnabled;
    statusByte[STAT_ACK_BIT] = acknowledgeActive;
    statusByte[STAT_END_BIT] = transferEndActive;
  end

  // Read path: one cycle from address to data.
  always_comb begin
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (alignedOf(araddr) == HW_REG_OFFSET) begin
        next_rdata = {24'h000000, hwReg};
      end else if (alignedOf(araddr) == STROBE_REG_OFFSET) begin
        next_rdata = {24'h000000, strobeReg};
      end else if (alignedOf(araddr) == STATUS_REG_OFFSET) begin
        next_rdata = {24'h000000, statusByte};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // The request pin is released only once; only reset takes it back.
  always_comb begin
    next_reqEnabled = reqEnabled || dmaConfigWrite;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reqEnabled <= 1'b0;
    end else begin
      reqEnabled <= next_reqEnabled;
    end
  end

  assign masterDma = hwReg[MASTER_BIT];
  assign cfg.byteLaneSwap = hwReg[SWAP_MSB:SWAP_LSB];
  assign cfg.genericActive = genericDmaActive;
  assign cfg.timedStrobe = masterDma && (transferMode == TIMED_MODE);
  assign cfg.strobeWidthCount = strobeReg[STROBE_CNT_MSB:0];

  strobe_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .startStrobe(startStrobe && masterDma),
    .startRead(startRead),
    .strobeActive(strobeActive),
    .strobeRead(strobeRead),
    .busy(strobeBusy)
  );

  lane_swap u_lanes (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .ramWord(ramWord),
    .busWordIn(busWordIn),
    .busWordOut(busWordOut),
    .ramWordOut(ramWordOut)
  );

  // Handshake pins stay combinational so a polarity change needs no extra pipeline stage.
  assign dmaRequestPin = levelOf(coreRequest, hwReg[REQ_LEVEL_BIT]);
  assign dmaRequestOe = reqEnabled;
  assign acknowledgeActive = levelOf(acknowledgePin, hwReg[ACK_LEVEL_BIT]);
  assign transferEndActive = !masterDma && levelOf(transferEndInput, hwReg[END_LEVEL_BIT]);
  assign readStrobeOe = masterDma;
  assign writeStrobeOe = masterDma;
  assign readStrobeOut = levelOf(strobeActive && strobeRead, hwReg[READ_LEVEL_BIT]);
  assign writeStrobeOut = levelOf(strobeActive && !strobeRead, hwReg[WRITE_LEVEL_BIT]);
  assign slaveReadStrobe = !masterDma && levelOf(readStrobeIn, hwReg[READ_LEVEL_BIT]);
  assign slaveWriteStrobe = !masterDma && levelOf(writeStrobeIn, hwReg[WRITE_LEVEL_BIT]);

  // Helper logic for checking strobe width.
  logic [STROBE_CNT_W-1:0] widthCnt, expWidth;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      widthCnt <= 8'h00;
      expWidth <= 8'h00;
    end else begin
      widthCnt <= strobeActive ? widthCnt + 8'h01 : 8'h00;
      if (startStrobe && masterDma && !strobeBusy) begin
        expWidth <= strobeCycles(cfg.timedStrobe ? cfg.strobeWidthCount : FIXED_STROBE_COUNT);
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_swap_lanes: assert property (
    (genericDmaActive && hwReg[SWAP_MSB:SWAP_LSB] == SWAP_ON) |=> busWordOut == swapBytes($past(ramWord)))
    else $error("swapped lanes not applied");
  chk_swap_generic_only: assert property (
    (!genericDmaActive || hwReg[SWAP_MSB:SWAP_LSB] != SWAP_ON) |=> busWordOut == $past(ramWord))
    else $error("lanes swapped outside generic mode");
  chk_end_level: assert property (
    transferEndActive == (!hwReg[MASTER_BIT] && (transferEndInput == hwReg[END_LEVEL_BIT])))
    else $error("end-of-transfer decode wrong");
  chk_role_drive: assert property (
    (!hwReg[MASTER_BIT]) |-> (!readStrobeOe && !writeStrobeOe && !strobeBusy))
    else $error("slave role drives strobes");
  chk_ack_level: assert property (
    acknowledgeActive == (acknowledgePin == hwReg[ACK_LEVEL_BIT]))
    else $error("acknowledge decode wrong");
  chk_req_level: assert property (
    dmaRequestPin == (coreRequest == hwReg[REQ_LEVEL_BIT]))
    else $error("request level wrong");
  chk_strobe_idle_level: assert property (
    !strobeBusy |-> (readStrobeOut == !hwReg[READ_LEVEL_BIT] && writeStrobeOut == !hwReg[WRITE_LEVEL_BIT]))
    else $error("idle strobe not at inactive level");
  chk_strobe_width: assert property (
    $fell(strobeBusy) |-> widthCnt == expWidth)
    else $error("strobe width differs from count plus one");
  chk_req_hold_off: assert property (
    $rose(dmaRequestOe) |-> $past(dmaConfigWrite))
    else $error("request pin driven before configuration write");
  chk_apply_next: assert property (
    (awHeld && wHeld && awAddrHeld == HW_REG_OFFSET && wLaneHeld) |=> hwReg == $past(wByteHeld))
    else $error("register write not applied next cycle");

  cov_timed_strobe: cover property ($fell(strobeBusy) && cfg.timedStrobe && strobeReg[4:0] == 5'h1f);
  cov_swap_active: cover property (genericDmaActive && hwReg[SWAP_MSB:SWAP_LSB] == SWAP_ON ##1 rvalid);
  cov_req_enable: cover property ($rose(dmaRequestOe) ##[1:20] bvalid);
endmodule
`default_nettype wire

// >>> dma_far_end.sv
// Purpose: Far-side DMA peer that drives the handshake inputs of the block.
// Assumes: The bench tells it which pin levels the device was set to.
// Notes: The request line counts only while the device drives it.
`timescale 1ns/1ps
`default_nettype none
module dma_far_end (
  input wire logic [7:0] levelSel,
  input wire logic ackOn,
  input wire logic endOn,
  input wire logic rdOn,
  input wire logic wrOn,
  input wire logic reqPin,
  input wire logic reqOe,
  output logic acknowledgePin,
  output logic transferEndInput,
  output logic readStrobeIn,
  output logic writeStrobeIn,
  output logic reqSeen
);
  // An idle pin sits at the opposite of its active level, never at a guess.
  assign acknowledgePin = ackOn ~^ levelSel[3];
  assign transferEndInput = endOn ~^ levelSel[5];
  assign readStrobeIn = rdOn ~^ levelSel[0];
  assign writeStrobeIn = wrOn ~^ levelSel[1];
  // A floating request line must never be mistaken for a request.
  assign reqSeen = reqOe & (reqPin ~^ levelSel[2]);
endmodule
`default_nettype wire

// >>> tb_dma_pin_config.sv
// Purpose: Self-checking bench for the DMA pin configuration block.
// Assumes: AXI4-Lite master tasks; peer model on the handshake pins.
// Notes: Ready flags are sampled mid-cycle, where they equal their edge value.
`timescale 1ns/1ps
`default_nettype none
module tb_dma_pin_config;
  import dma_cfg_pkg::*;
  logic core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, transferMode;
  logic dmaConfigWrite, genericDmaActive, coreRequest, startStrobe, startRead, reqSeen;
  logic [15:0] ramWord, busWordIn, busWordOut, ramWordOut;
  logic dmaRequestPin, dmaRequestOe, acknowledgePin, transferEndInput, readStrobeIn, readStrobeOut;
  logic readStrobeOe, writeStrobeIn, writeStrobeOut, writeStrobeOe, acknowledgeActive, transferEndActive;
  logic slaveReadStrobe, slaveWriteStrobe, strobeBusy, ackOn, endOn, rdOn, wrOn;
  logic [7:0] levelSel;
  int nErrors, testsRun;
  dma_pin_config i_dut (.core_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .dmaConfigWrite,
    .transferMode, .genericDmaActive, .coreRequest, .startStrobe, .startRead, .ramWord, .busWordIn,
    .busWordOut, .ramWordOut, .dmaRequestPin, .dmaRequestOe, .acknowledgePin, .transferEndInput,
    .readStrobeIn, .readStrobeOut, .readStrobeOe, .writeStrobeIn, .writeStrobeOut, .writeStrobeOe,
    .acknowledgeActive, .transferEndActive, .slaveReadStrobe, .slaveWriteStrobe, .strobeBusy);
  dma_far_end i_peer (.levelSel, .ackOn, .endOn, .rdOn, .wrOn, .reqPin(dmaRequestPin), .reqOe(dmaRequestOe),
    .acknowledgePin, .transferEndInput, .readStrobeIn, .writeStrobeIn, .reqSeen);
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic closeOut;
    if (nErrors == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (pa || pw) begin
      @(negedge core_clk);
      ta = awready;
      tw = wready;
      @(posedge core_clk);
      if (pa && ta) begin
        awvalid <= 1'h0;
        pa = 1'h0;
      end
      if (pw && tw) begin
        wvalid <= 1'h0;
        pw = 1'h0;
      end
    end
    do @(negedge core_clk); while (bvalid !== 1'h1);
    @(posedge core_clk);
    r = bresp;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    do @(negedge core_clk); while (arready !== 1'h1);
    @(posedge core_clk);
    arvalid <= 1'h0;
    do @(negedge core_clk); while (rvalid !== 1'h1);
    @(posedge core_clk);
    d = rdata;
    r = rresp;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] r;
    axw(a, {24'h0, v}, 4'hf, r);
    chk(r, RESP_OKAY);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, e);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rchk(HW_REG_OFFSET, 32'h04);
    rchk(STROBE_REG_OFFSET, 32'h1f);
    axr(8'h10, d, r);
    chk(r, RESP_SLVERR);
    axw(8'h10, 32'hff, 4'hf, r);
    chk(r, RESP_SLVERR);
    axw(STROBE_REG_OFFSET, 32'h00, 4'he, r);
    rchk(STROBE_REG_OFFSET, 32'h1f);
    // The status word is read-only; a write to it is answered but changes nothing.
    wreg(STATUS_REG_OFFSET, 8'hff);
    wreg(STROBE_REG_OFFSET, 8'he5);
    rchk(STROBE_REG_OFFSET, 32'he5);
  endtask
  task automatic t_levels(input logic [7:0] v);
    wreg(HW_REG_OFFSET, v);
    levelSel <= v;
    for (int k = 0; k < 2; k++) begin
      ackOn <= k[0];
      endOn <= k[0];
      rdOn <= k[0];
      wrOn <= k[0];
      coreRequest <= k[0];
      @(negedge core_clk);
      chk(acknowledgeActive, k[0]);
      chk(transferEndActive, k[0]);
      chk(slaveReadStrobe, k[0]);
      chk(slaveWriteStrobe, k[0]);
      chk(dmaRequestPin, k[0] == v[2]);
      chk(readStrobeOut, !v[0]);
      chk(writeStrobeOut, !v[1]);
      chk(readStrobeOe, 1'h0);
      @(posedge core_clk);
    end
    startStrobe <= 1'h1;
    @(posedge core_clk);
    startStrobe <= 1'h0;
    @(negedge core_clk);
    chk(strobeBusy, 1'h0);
    @(posedge core_clk);
    wreg(HW_REG_OFFSET, v | 8'h10);
    @(negedge core_clk);
    chk(transferEndActive, 1'h0);
    chk(slaveReadStrobe, 1'h0);
    chk({readStrobeOe, writeStrobeOe}, 2'h3);
    @(posedge core_clk);
  endtask
  task automatic t_request;
    chk({dmaRequestOe, reqSeen}, 2'h0);
    // Acknowledge is held active by the peer here, so only the request-enable bit may change.
    rchk(STATUS_REG_OFFSET, 32'h04);
    dmaConfigWrite <= 1'h1;
    @(posedge core_clk);
    dmaConfigWrite <= 1'h0;
    @(negedge core_clk);
    chk({dmaRequestOe, reqSeen}, 2'h3);
    @(posedge core_clk);
    rchk(STATUS_REG_OFFSET, 32'h06);
  endtask
  task automatic t_strobe(input logic [1:0] m, input logic [4:0] n, input logic rd, input logic [7:0] v);
    int w;
    int e;
    e = (m == TIMED_MODE) ? (n + 1) : (FIXED_STROBE_COUNT + 1);
    e = e * STROBE_UNIT_CYCLES;
    transferMode <= m;
    wreg(STROBE_REG_OFFSET, {3'h0, n});
    wreg(HW_REG_OFFSET, v);
    startStrobe <= 1'h1;
    startRead <= rd;
    @(posedge core_clk);
    startStrobe <= 1'h0;
    w = 0;
    @(negedge core_clk);
    while (strobeBusy === 1'h1 && w < 80) begin
      chk(rd ? readStrobeOut : writeStrobeOut, rd ? v[0] : v[1]);
      w++;
      @(negedge core_clk);
    end
    chk(w, e);
    @(posedge core_clk);
  endtask
  task automatic t_lanes;
    logic sw;
    for (int c = 0; c < 8; c++) begin
      wreg(HW_REG_OFFSET, {c[1:0], 6'h04});
      genericDmaActive <= c[2];
      ramWord <= 16'h12ab;
      busWordIn <= 16'h34cd;
      @(posedge core_clk);
      @(negedge core_clk);
      sw = c[2] && (c[1:0] == 2'h1);
      chk(busWordOut, sw ? 16'hab12 : 16'h12ab);
      chk(ramWordOut, sw ? 16'hcd34 : 16'h34cd);
      @(posedge core_clk);
      rchk(HW_REG_OFFSET, {24'h0, c[1:0], 6'h04});
    end
    // Leave the swap code normal, as an 8-bit bus would need.
    wreg(HW_REG_OFFSET, 8'h04);
  endtask
  initial begin
    {rst_n, awvalid, wvalid, arvalid, dmaConfigWrite, genericDmaActive, coreRequest} = 7'h0;
    {startStrobe, startRead, ackOn, endOn, rdOn, wrOn} = 6'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata, wstrb, transferMode, ramWord, busWordIn} = 86'h0;
    levelSel = 8'h04;
    nErrors = 0;
    testsRun = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    t_regs();
    t_levels(8'h00);
    t_levels(8'h2f);
    t_request();
    t_strobe(TIMED_MODE, 5'h00, 1'h1, 8'h11);
    t_strobe(TIMED_MODE, 5'h1f, 1'h0, 8'h12);
    t_strobe(2'h1, 5'h05, 1'h1, 8'h10);
    t_lanes();
    closeOut();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    closeOut();
  end
endmodule
`default_nettype wire
